/* File: twm_master.sv */
`timescale 1ns/1ps
`include "twm_consts.svh"
module twm_master #(
  parameter int LOW_CYC = `TWM_LOW_CYC,
  parameter int HIGH_CYC = `TWM_HIGH_CYC,
  parameter int BUF_DEPTH = `TWM_BUF_DEPTH
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  // control writes
  input wire logic ctrl_wr_in,
  input wire twm_pkg::twm_ctrl_s ctrl_in,
  input wire logic [6:0] own_addr_in,
  // byte stream into the shift register
  input wire logic data_valid_in,
  input wire logic [7:0] data_in,
  output logic data_ready_out,
  // status
  output logic op_done_flag_out,
  output twm_pkg::twm_status_t bus_status_out,
  output logic [7:0] shift_data_out,
  output logic slave_mode_out,
  // open-drain bus pins
  input wire twm_pkg::twm_pins_s pins_in,
  output twm_pkg::twm_pins_s pins_out,
  output twm_pkg::twm_pins_s pins_oe_out
);
  import twm_pkg::*;

  localparam twm_cnt_t LOW_M1 = twm_cnt_t'(LOW_CYC - 1);
  localparam twm_cnt_t HIGH_M1 = twm_cnt_t'(HIGH_CYC - 1);

  twm_state_e state_reg;
  twm_cnt_t cnt_reg;
  logic [3:0] bit_idx_reg;
  logic [7:0] shift_data_reg;
  twm_ctrl_s bus_control_reg;
  twm_status_t bus_status_reg;
  twm_pins_s pins_oe_reg;
  twm_pins_s pins_s;
  logic [1:0] pins_sync;
  logic cmd_pend_reg;
  logic op_done_flag_reg;
  logic addr_phase_reg;
  logic slave_mode_reg;
  logic scl_prev_reg;
  logic sda_prev_reg;
  logic buf_valid;
  logic [7:0] buf_data;
  logic go;
  logic bus_free;
  logic low_done;
  logic high_done;
  logic ack_slot;
  logic scl_rise;
  logic stop_seen;
  logic arb_lost;
  logic byte_end;
  logic start_end;
  logic slave_hit;
  logic launch;
  logic cmd_take;
  logic done_set;
  twm_status_t done_code;

  // ----------------------------------------
  // pin sampling and byte buffer
  // ----------------------------------------
  twm_sync #(.W(2)) u_sync (
    .clk_sys_in(clk_sys_in),
    .sys_rst_in(sys_rst_in),
    .async_in({pins_in.scl, pins_in.sda}),
    .sync_out(pins_sync)
  );

  assign pins_s.scl = pins_sync[1];
  assign pins_s.sda = pins_sync[0];

  // a stalled engine leaves words here and back-pressures the writer
  twm_buf #(.W(8), .DEPTH(BUF_DEPTH)) u_buf (
    .clk_sys_in(clk_sys_in),
    .sys_rst_in(sys_rst_in),
    .in_valid_in(data_valid_in),
    .in_data_in(data_in),
    .in_ready_out(data_ready_out),
    .out_valid_out(buf_valid),
    .out_data_out(buf_data),
    .out_ready_in(launch)
  );

  // ----------------------------------------
  // events
  // ----------------------------------------
  always_comb begin
    go = !op_done_flag_reg && cmd_pend_reg;
    bus_free = pins_s.scl && pins_s.sda;
    low_done = (cnt_reg >= LOW_M1);
    high_done = (cnt_reg >= HIGH_M1);
    ack_slot = (bit_idx_reg == `TWM_ACK_BIT);
    scl_rise = pins_s.scl && !scl_prev_reg;
    stop_seen = pins_s.scl && pins_s.sda && !sda_prev_reg;
    // only a released one can lose, so the winner's bits stay intact on the wire
    arb_lost = (state_reg == ST_BIT_HIGH) && !ack_slot && shift_data_reg[7] && !pins_s.sda;
    byte_end = (state_reg == ST_BIT_HIGH) && ack_slot && (high_done || !pins_s.scl);
    start_end = (state_reg == ST_START_HOLD) && high_done;
    slave_hit = (state_reg == ST_SLAVE) && ack_slot && addr_phase_reg && (shift_data_reg[7:1] == own_addr_in);
    launch = (state_reg == ST_HOLD) && go && !bus_control_reg.start && !bus_control_reg.stop && buf_valid;
    cmd_take = go && (((state_reg == ST_IDLE) && (!bus_control_reg.start || bus_free)) ||
                      ((state_reg == ST_HOLD) && (bus_control_reg.start || bus_control_reg.stop || buf_valid)));
    done_set = start_end || byte_end || arb_lost || slave_hit;
    if (start_end) begin
      done_code = `TWM_ST_START_OK;
    end else if (arb_lost) begin
      done_code = `TWM_ST_ARB_LOST;
    end else if (slave_hit) begin
      done_code = `TWM_ST_SLAVE_HIT;
    end else if (addr_phase_reg) begin
      done_code = pins_s.sda ? `TWM_ST_ADDR_NACK : `TWM_ST_ADDR_ACK;
    end else begin
      done_code = pins_s.sda ? `TWM_ST_DATA_NACK : `TWM_ST_DATA_ACK;
    end
  end

  // ----------------------------------------
  // bus sequencer
  // ----------------------------------------
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state_reg <= ST_IDLE;
      cnt_reg <= '0;
      bit_idx_reg <= '0;
      shift_data_reg <= '0;
      pins_oe_reg <= '0;
      addr_phase_reg <= 1'b0;
      slave_mode_reg <= 1'b0;
    end else begin
      cnt_reg <= twm_cnt_t'(cnt_reg + 1'b1);
      unique case (state_reg)
        ST_IDLE: begin
          pins_oe_reg <= '0;
          slave_mode_reg <= 1'b0;
          if (cmd_take && bus_control_reg.start) begin
            pins_oe_reg.sda <= 1'b1;
            cnt_reg <= '0;
            state_reg <= ST_START_HOLD;
          end
        end
        ST_START_HOLD: begin
          if (start_end) begin
            pins_oe_reg.scl <= 1'b1;
            addr_phase_reg <= 1'b1;
            state_reg <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          pins_oe_reg.scl <= 1'b1;
          if (cmd_take) begin
            cnt_reg <= '0;
            if (bus_control_reg.start) begin
              pins_oe_reg.sda <= 1'b0;
              state_reg <= ST_RS_LOW;
            end else if (bus_control_reg.stop) begin
              pins_oe_reg.sda <= 1'b1;
              state_reg <= ST_STOP_LOW;
            end else begin
              shift_data_reg <= buf_data;
              bit_idx_reg <= '0;
              pins_oe_reg.sda <= !buf_data[7];
              state_reg <= ST_BIT_LOW;
            end
          end
        end
        ST_RS_LOW: begin
          if (low_done) begin
            pins_oe_reg.scl <= 1'b0;
            state_reg <= ST_RS_REL;
          end
        end
        ST_RS_REL: begin
          if (pins_s.scl) begin
            pins_oe_reg.sda <= 1'b1;
            cnt_reg <= '0;
            state_reg <= ST_START_HOLD;
          end
        end
        ST_BIT_LOW: begin
          if (low_done) begin
            pins_oe_reg.scl <= 1'b0;
            state_reg <= ST_BIT_REL;
          end
        end
        ST_BIT_REL: begin
          // a slower master still holding the line stretches our low time
          if (pins_s.scl) begin
            cnt_reg <= '0;
            state_reg <= ST_BIT_HIGH;
          end
        end
        ST_BIT_HIGH: begin
          if (arb_lost) begin
            pins_oe_reg <= '0;
            shift_data_reg <= {shift_data_reg[6:0], 1'b0};
            bit_idx_reg <= 4'(bit_idx_reg + 1'b1);
            slave_mode_reg <= 1'b1;
            state_reg <= ST_SLAVE;
          end else if (byte_end) begin
            pins_oe_reg.scl <= 1'b1;
            pins_oe_reg.sda <= 1'b0;
            addr_phase_reg <= 1'b0;
            state_reg <= ST_HOLD;
          end else if (high_done || !pins_s.scl) begin
            // an early fall from another master ends our high time too
            pins_oe_reg.scl <= 1'b1;
            pins_oe_reg.sda <= (bit_idx_reg == 4'h7) ? 1'b0 : !shift_data_reg[6];
            shift_data_reg <= {shift_data_reg[6:0], shift_data_reg[7]};
            bit_idx_reg <= 4'(bit_idx_reg + 1'b1);
            cnt_reg <= '0;
            state_reg <= ST_BIT_LOW;
          end
        end
        ST_STOP_LOW: begin
          if (low_done) begin
            pins_oe_reg.scl <= 1'b0;
            state_reg <= ST_STOP_REL;
          end
        end
        ST_STOP_REL: begin
          if (pins_s.scl) begin
            cnt_reg <= '0;
            state_reg <= ST_STOP_HIGH;
          end
        end
        ST_STOP_HIGH: begin
          if (high_done) begin
            pins_oe_reg.sda <= 1'b0;
            state_reg <= ST_IDLE;
          end
        end
        ST_SLAVE: begin
          // only the address match is checked; no slave answer is given
          if (stop_seen) begin
            state_reg <= ST_IDLE;
          end else if (ack_slot) begin
            addr_phase_reg <= 1'b0;
          end else if (scl_rise) begin
            shift_data_reg <= {shift_data_reg[6:0], pins_s.sda};
            bit_idx_reg <= 4'(bit_idx_reg + 1'b1);
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // completion flag and control
  // ----------------------------------------
  // a completion in the cycle of a clearing write keeps the flag set
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      op_done_flag_reg <= 1'b0;
    end else if (done_set) begin
      op_done_flag_reg <= 1'b1;
    end else if (ctrl_wr_in && ctrl_in.done_clr) begin
      op_done_flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      bus_control_reg <= '0;
      cmd_pend_reg <= 1'b0;
    end else begin
      if (ctrl_wr_in) begin
        bus_control_reg <= ctrl_in;
      end
      if (ctrl_wr_in && ctrl_in.done_clr) begin
        cmd_pend_reg <= 1'b1;
      end else if (cmd_take) begin
        cmd_pend_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      bus_status_reg <= `TWM_ST_RESET;
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else begin
      scl_prev_reg <= pins_s.scl;
      sda_prev_reg <= pins_s.sda;
      if (done_set) begin
        bus_status_reg <= done_code;
      end
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign pins_out = '0;
  assign pins_oe_out = pins_oe_reg;
  assign op_done_flag_out = op_done_flag_reg;
  assign bus_status_out = bus_status_reg;
  assign shift_data_out = shift_data_reg;
  assign slave_mode_out = slave_mode_reg;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);

  AST_NO_OP_WHILE_FLAG: assert property ((state_reg == ST_HOLD) && op_done_flag_reg |=> state_reg == ST_HOLD)
    else $error("engine left hold while flag set");
  AST_FLAG_CLEAR: assert property (ctrl_wr_in && ctrl_in.done_clr && !done_set |=> !op_done_flag_reg)
    else $error("write of one did not clear flag");
  AST_FLAG_KEEP: assert property (ctrl_wr_in && !ctrl_in.done_clr && op_done_flag_reg |=> op_done_flag_reg)
    else $error("write of zero changed flag");
  AST_LAUNCH: assert property (launch |=> state_reg == ST_BIT_LOW && shift_data_reg == $past(buf_data))
    else $error("address or data launch missed");
  AST_ADDR_DONE: assert property (byte_end && addr_phase_reg |=> op_done_flag_reg &&
      bus_status_reg == ($past(pins_s.sda) ? `TWM_ST_ADDR_NACK : `TWM_ST_ADDR_ACK))
    else $error("address completion not reported");
  AST_DATA_DONE: assert property (byte_end && !addr_phase_reg |=> op_done_flag_reg &&
      bus_status_reg == ($past(pins_s.sda) ? `TWM_ST_DATA_NACK : `TWM_ST_DATA_ACK))
    else $error("data completion not reported");
  AST_STOP_NO_FLAG: assert property ((state_reg == ST_STOP_HIGH) && high_done |=>
      state_reg == ST_IDLE && !pins_oe_reg.sda ##1 $stable(op_done_flag_reg))
    else $error("stop end changed flag or bus");
  AST_HOLD_SCL: assert property (op_done_flag_reg && (state_reg == ST_HOLD) |=> pins_oe_reg.scl)
    else $error("clock line not held while flag set");
  AST_ARB_RELEASE: assert property (arb_lost |=> !pins_oe_reg.scl && !pins_oe_reg.sda && slave_mode_reg)
    else $error("lost arbitration without release");
  AST_LOW_STRETCH: assert property ((state_reg == ST_BIT_REL) && !pins_s.scl |=> state_reg == ST_BIT_REL)
    else $error("high phase began while line low");
  AST_HIGH_RESTART: assert property ((state_reg == ST_BIT_HIGH) && !pins_s.scl |=>
      state_reg != ST_BIT_HIGH && (state_reg != ST_BIT_LOW || cnt_reg == '0))
    else $error("high phase not ended by line fall");

  COV_START: cover property (start_end);
  COV_ADDR_ACK: cover property (byte_end && addr_phase_reg && !pins_s.sda);
  COV_STOP: cover property ((state_reg == ST_STOP_HIGH) ##1 (state_reg == ST_IDLE));
  COV_ARB: cover property (arb_lost);

endmodule : twm_master

/* File: twm_consts.svh */
`ifndef TWM_CONSTS_SVH
`define TWM_CONSTS_SVH

// ----------------------------------------
// timing
// ----------------------------------------
`define TWM_CLK_NS 40
`define TWM_T_LOW_NS 5000
`define TWM_T_HIGH_NS 5000
`define TWM_LOW_CYC ((`TWM_T_LOW_NS + `TWM_CLK_NS - 1) / `TWM_CLK_NS)
`define TWM_HIGH_CYC ((`TWM_T_HIGH_NS + `TWM_CLK_NS - 1) / `TWM_CLK_NS)

// ----------------------------------------
// sizes
// ----------------------------------------
`define TWM_BUF_DEPTH 2
`define TWM_ACK_BIT 4'h8

// ----------------------------------------
// status codes
// ----------------------------------------
`define TWM_ST_RESET 8'hFF
`define TWM_ST_START_OK 8'h01
`define TWM_ST_ADDR_ACK 8'h02
`define TWM_ST_ADDR_NACK 8'h03
`define TWM_ST_DATA_ACK 8'h04
`define TWM_ST_DATA_NACK 8'h05
`define TWM_ST_ARB_LOST 8'h06
`define TWM_ST_SLAVE_HIT 8'h07

`endif

/* File: twm_pkg.sv */
package twm_pkg;

  typedef logic [7:0] twm_status_t;
  typedef logic [15:0] twm_cnt_t;

  // one write of bus_control_reg
  typedef struct packed {
    logic done_clr;
    logic start;
    logic stop;
  } twm_ctrl_s;

  typedef struct packed {
    logic scl;
    logic sda;
  } twm_pins_s;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_START_HOLD,
    ST_HOLD,
    ST_RS_LOW,
    ST_RS_REL,
    ST_BIT_LOW,
    ST_BIT_REL,
    ST_BIT_HIGH,
    ST_STOP_LOW,
    ST_STOP_REL,
    ST_STOP_HIGH,
    ST_SLAVE
  } twm_state_e;

endpackage : twm_pkg

/* File: twm_sync.sv */
`timescale 1ns/1ps
module twm_sync #(
  parameter int W = 2
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  // level crossing
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta_reg;

  // resets to ones: an idle open-drain bus reads high
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      meta_reg <= '1;
      sync_out <= '1;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule : twm_sync

/* File: twm_buf.sv */
`timescale 1ns/1ps
module twm_buf #(
  parameter int W = 8,
  parameter int DEPTH = 2
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  // fill side
  input wire logic in_valid_in,
  input wire logic [W-1:0] in_data_in,
  output logic in_ready_out,
  // drain side
  output logic out_valid_out,
  output logic [W-1:0] out_data_out,
  input wire logic out_ready_in
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [W-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr_reg;
  logic [PW-1:0] rd_ptr_reg;
  logic [CW-1:0] count_reg;
  logic [CW-1:0] count_next;
  logic push;
  logic pop;

  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;
  assign out_valid_out = (count_reg != '0);
  assign out_data_out = mem[rd_ptr_reg];

  always_comb begin
    count_next = count_reg;
    if (push && !pop) begin
      count_next = CW'(count_reg + 1'b1);
    end else if (pop && !push) begin
      count_next = CW'(count_reg - 1'b1);
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data_in;
    end
  end

  // ready is registered so the port comes straight from a flip-flop
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
      in_ready_out <= 1'b1;
    end else begin
      count_reg <= count_next;
      in_ready_out <= (count_next != CW'(DEPTH));
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == PW'(DEPTH - 1)) ? '0 : PW'(wr_ptr_reg + 1'b1);
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == PW'(DEPTH - 1)) ? '0 : PW'(rd_ptr_reg + 1'b1);
      end
    end
  end

endmodule : twm_buf

/* File: twm_slave_model.sv */
`timescale 1ns/1ps
// --------
// far-side slave: acknowledge and clock stretch
// --------
module twm_slave_model (
  // clock
  input wire logic clk_sys_in,
  // bus wires and behaviour knobs
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic ack_en_in,
  input wire logic [7:0] stretch_in,
  // pull-low enables and observations
  output logic scl_oe_out,
  output logic sda_oe_out,
  output logic [7:0] byte_out,
  output logic [7:0] stop_cnt_out
);
  logic scl_q;
  logic sda_q;
  logic [3:0] bit_cnt;
  logic [7:0] shift_reg;
  logic [7:0] hold_cnt;

  initial begin
    {scl_q, sda_q, scl_oe_out, sda_oe_out} = 4'h0;
    {bit_cnt, shift_reg, hold_cnt, byte_out, stop_cnt_out} = 36'h0_0000_0000;
  end

  // sampled on the system clock so start, stop and bit edges never race
  always @(posedge clk_sys_in) begin
    scl_q <= scl_in;
    sda_q <= sda_in;
    scl_oe_out <= (hold_cnt != 8'h00); // low time of the slowest party wins
    if (hold_cnt != 8'h00) hold_cnt <= hold_cnt - 8'h01;
    if (scl_q && scl_in && sda_q && !sda_in) begin
      bit_cnt <= 4'h0;
    end else if (scl_q && scl_in && !sda_q && sda_in) begin
      bit_cnt <= 4'h0;
      sda_oe_out <= 1'b0;
      stop_cnt_out <= stop_cnt_out + 8'h01;
    end else if (!scl_q && scl_in) begin
      if (bit_cnt < 4'h8) shift_reg <= {shift_reg[6:0], sda_in}; // msb first
      bit_cnt <= bit_cnt + 4'h1;
    end else if (scl_q && !scl_in) begin
      hold_cnt <= stretch_in;
      sda_oe_out <= (bit_cnt == 4'h8) && ack_en_in;
      if (bit_cnt == 4'h9) begin
        bit_cnt <= 4'h0;
        byte_out <= shift_reg;
      end
    end
  end
endmodule : twm_slave_model

/* File: two_wire_master_handshake_test.sv */
`timescale 1ns/1ps
`include "twm_consts.svh"
module two_wire_master_handshake_test;
  import twm_pkg::*;
  localparam int LOW = 4;
  localparam int HIGH = 4;
  localparam int STRETCH = 20;
  typedef struct {logic [1:0] op; logic [7:0] b; logic ack; logic [7:0] st;} twm_row_s;
  logic clk_sys_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic ctrl_wr, data_valid, data_ready, flag, slave_mode, tb_sda_oe, ack_en, scl_w, sda_w, sl_scl, sl_sda;
  logic tb_scl_oe;
  twm_ctrl_s ctrl;
  logic [7:0] data, shift, stretch, sl_byte, stop_cnt;
  twm_status_t status;
  twm_pins_s oe, pins_w;
  int error_cnt = 0;
  int compares = 0;
  int low_run, high_run, max_low, min_high, wt;
  // op 0 start, 1 byte, 2 stop
  twm_row_s rows [8] = '{'{2'd0, 8'h00, 1'b1, `TWM_ST_START_OK}, '{2'd1, 8'hA4, 1'b1, `TWM_ST_ADDR_ACK},
    '{2'd1, 8'h5A, 1'b1, `TWM_ST_DATA_ACK}, '{2'd1, 8'h3C, 1'b0, `TWM_ST_DATA_NACK}, '{2'd2, 8'h00, 1'b1, 8'h00},
    '{2'd0, 8'h00, 1'b1, `TWM_ST_START_OK}, '{2'd1, 8'hA5, 1'b0, `TWM_ST_ADDR_NACK}, '{2'd2, 8'h00, 1'b0, 8'h00}};

  always #20 clk_sys_in = ~clk_sys_in;
  // --------
  // open-drain wires with pull-ups
  // --------
  assign scl_w = !(oe.scl | sl_scl | tb_scl_oe);
  assign sda_w = !(oe.sda | sl_sda | tb_sda_oe);
  assign pins_w = {scl_w, sda_w};

  twm_master #(.LOW_CYC(LOW), .HIGH_CYC(HIGH), .BUF_DEPTH(2)) u_dut (.clk_sys_in(clk_sys_in),
    .sys_rst_in(sys_rst_in), .ctrl_wr_in(ctrl_wr), .ctrl_in(ctrl), .own_addr_in(7'h2A),
    .data_valid_in(data_valid), .data_in(data), .data_ready_out(data_ready), .op_done_flag_out(flag),
    .bus_status_out(status), .shift_data_out(shift), .slave_mode_out(slave_mode), .pins_in(pins_w),
    .pins_out(), .pins_oe_out(oe));
  twm_slave_model u_slave (.clk_sys_in(clk_sys_in), .scl_in(scl_w), .sda_in(sda_w), .ack_en_in(ack_en),
    .stretch_in(stretch), .scl_oe_out(sl_scl), .sda_oe_out(sl_sda), .byte_out(sl_byte), .stop_cnt_out(stop_cnt));

  // longest low and shortest high of the shared clock since the last control write
  always @(posedge clk_sys_in) begin
    if (scl_w) begin
      high_run++;
      if (low_run > max_low) max_low = low_run;
      low_run = 0;
    end else begin
      if (high_run != 0 && high_run < min_high) min_high = high_run;
      high_run = 0;
      low_run++;
    end
  end

  // --------
  // shared tasks
  // --------
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : complete_run

  task automatic timed_out(input string nm);
    error_cnt++;
    $display("[FAIL] %s expected completion seen timeout", nm);
    complete_run();
  endtask : timed_out

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys_in);
  endtask : cyc

  task automatic write_ctrl(input logic clr, input logic st, input logic sp);
    @(negedge clk_sys_in);
    ctrl_wr = 1'b1;
    ctrl = {clr, st, sp};
    @(negedge clk_sys_in);
    ctrl_wr = 1'b0;
  endtask : write_ctrl

  task automatic push_byte(input logic [7:0] b);
    int i;
    @(negedge clk_sys_in);
    data_valid = 1'b1;
    data = b;
    for (i = 0; i < 50 && data_ready !== 1'b1; i++) @(negedge clk_sys_in);
    if (i == 50) timed_out("buffer ready");
    @(negedge clk_sys_in);
    data_valid = 1'b0;
  endtask : push_byte

  task automatic wait_flag;
    int i;
    for (i = 0; i < 2000 && flag !== 1'b1; i++) @(negedge clk_sys_in);
    if (i == 2000) timed_out("completion flag");
  endtask : wait_flag

  task automatic do_op(input logic [1:0] op, input logic [7:0] b, input logic psh, input logic ack,
                       input logic [7:0] st);
    int i;
    logic [7:0] sc;
    ack_en = ack;
    if (op == 2'd1 && psh) push_byte(b); // loaded while the flag is set
    if (flag === 1'b1) begin
      write_ctrl(1'b0, op == 2'd0, op == 2'd2);
      cyc(10);
      chk("flag kept by zero write", flag, 8'h01);
      chk("scl held low", oe.scl, 8'h01);
    end
    sc = stop_cnt;
    write_ctrl(1'b1, op == 2'd0, op == 2'd2); // control written last
    {low_run, high_run, max_low, min_high} = {32'd0, 32'd0, 32'd0, 32'd1000};
    if (op == 2'd2) begin
      for (i = 0; i < 2000 && stop_cnt == sc; i++) @(negedge clk_sys_in);
      if (i == 2000) timed_out("stop on bus");
      cyc(5);
      chk("flag after stop", flag, 8'h00);
      chk("pins after stop", oe, 8'h00);
    end else begin
      wait_flag();
      cyc(2);
      chk("status", status, st);
      if (op == 2'd1) chk("byte on bus", sl_byte, b);
      if (op == 2'd1) chk("shift register", shift, b);
    end
  endtask : do_op

  task automatic reset_chk;
    sys_rst_in = 1'b1;
    cyc(3);
    chk("reset outputs", {oe, flag, slave_mode, data_ready}, 8'h01);
    chk("reset status", status, `TWM_ST_RESET);
    chk("reset shift", shift, 8'h00);
    sys_rst_in = 1'b0;
  endtask : reset_chk

  // --------
  // main sequence
  // --------
  initial begin
    {ctrl_wr, ctrl, data_valid, data, tb_sda_oe, tb_scl_oe, ack_en, stretch} = 24'h00_0000;
    reset_chk();
    $display("reset test done");
    foreach (rows[k]) do_op(rows[k].op, rows[k].b, 1'b1, rows[k].ack, rows[k].st);
    $display("table test done");
    // slow slave while the buffer is full
    stretch = STRETCH;
    do_op(2'd0, 8'h00, 1'b0, 1'b1, `TWM_ST_START_OK);
    push_byte(8'hC3);
    push_byte(8'h69);
    cyc(2);
    chk("buffer refuses third", data_ready, 8'h00);
    do_op(2'd1, 8'hC3, 1'b0, 1'b1, `TWM_ST_ADDR_ACK);
    chk("longest low wins", max_low >= STRETCH && max_low <= STRETCH + LOW, 8'h01);
    chk("high counted from rise", min_high >= HIGH, 8'h01);
    do_op(2'd1, 8'h69, 1'b0, 1'b1, `TWM_ST_DATA_ACK);
    chk("buffer drained", data_ready, 8'h01);
    do_op(2'd2, 8'h00, 1'b0, 1'b1, 8'h00);
    stretch = 8'h00;
    $display("buffer and stretch test done");
    // a faster master pulls the clock low early in the first high phase
    do_op(2'd0, 8'h00, 1'b0, 1'b1, `TWM_ST_START_OK);
    push_byte(8'h96);
    write_ctrl(1'b1, 1'b0, 1'b0);
    for (wt = 0; wt < 50 && scl_w !== 1'b1; wt++) cyc(1);
    if (wt == 50) timed_out("clock release");
    cyc(2);
    tb_scl_oe = 1'b1;
    cyc(6);
    tb_scl_oe = 1'b0;
    wait_flag();
    cyc(2);
    chk("status after short high", status, `TWM_ST_ADDR_ACK);
    chk("byte with short high", sl_byte, 8'h96);
    do_op(2'd2, 8'h00, 1'b0, 1'b1, 8'h00);
    $display("short high test done");
    // a competing master holds data low while this one sends ones
    do_op(2'd0, 8'h00, 1'b0, 1'b1, `TWM_ST_START_OK);
    push_byte(8'hFF);
    write_ctrl(1'b1, 1'b0, 1'b0);
    tb_sda_oe = 1'b1;
    wait_flag();
    cyc(2);
    chk("status after loss", status, `TWM_ST_ARB_LOST);
    chk("slave mode after loss", slave_mode, 8'h01);
    chk("pins after loss", oe, 8'h00);
    tb_sda_oe = 1'b0;
    cyc(10);
    chk("winner data intact", sda_w, 8'h01);
    chk("slave mode left on stop", slave_mode, 8'h00);
    $display("arbitration test done");
    reset_chk();
    do_op(2'd0, 8'h00, 1'b0, 1'b1, `TWM_ST_START_OK);
    $display("mid-run reset test done");
    complete_run();
  end
endmodule : two_wire_master_handshake_test
